// ===== include/acc_pkg.sv
// Constants for the conversion control block: offsets, fields, resets, timing
package acc_pkg;

    // Register byte offsets
    localparam logic [4:0] OFF_CTRL0   = 5'h00;
    localparam logic [4:0] OFF_CTRL1   = 5'h04;
    localparam logic [4:0] OFF_RES_HI  = 5'h08;
    localparam logic [4:0] OFF_RES_LO  = 5'h0c;
    localparam logic [4:0] OFF_PINSEL  = 5'h10;
    localparam logic [4:0] OFF_IRQ     = 5'h14;

    // Control zero fields
    localparam int CTRL0_START = 7;
    localparam int CTRL0_BUSY  = 6;
    localparam int CTRL0_EN    = 5;
    localparam int CTRL0_ALIGN = 4;
    localparam int CTRL0_CHAN  = 0;

    // Control one fields
    localparam int CTRL1_SRC   = 5;
    localparam int CTRL1_REF   = 3;
    localparam int CTRL1_DIV   = 0;

    // Interrupt register fields
    localparam int IRQ_FLAG    = 0;
    localparam int IRQ_ENABLE  = 1;

    // Reset values
    localparam logic [7:0]  CTRL0_RESET  = 8'h00;
    localparam logic [7:0]  CTRL1_RESET  = 8'h00;
    localparam logic [7:0]  PINSEL_RESET = 8'h00;
    localparam logic [11:0] RESULT_RESET = 12'h000;

    // Input source select codes
    localparam logic [2:0] SRC_EXT0     = 3'h0;
    localparam logic [2:0] SRC_BANDGAP  = 3'h1;
    localparam logic [2:0] SRC_GND_LO   = 3'h2;
    localparam logic [2:0] SRC_GND_HI   = 3'h4;

    // Conversion timing in conversion-clock cycles
    localparam logic [3:0] SAMPLE_CYCLES  = 4'h4;
    localparam logic [3:0] CONVERT_CYCLES = 4'hc;

    // Sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_ARMED,
        SEQ_SAMPLE,
        SEQ_CONVERT
    } acc_seq_t;

endpackage

// ===== rtl/acc_clk_div.sv
// Conversion clock tick generator: system clock divided by a power of two
`timescale 1ns/1ns
module acc_clk_div #(
    parameter int DIV_W = 3
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Control
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] divSel,
    // Tick out
    output logic                  tick
);
    localparam int CNT_W = (1 << DIV_W) - 1;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] mask;

    // Low divSel bits of the counter all ones marks one conversion period
    always_comb begin
        mask = CNT_W'((1 << divSel) - 1);
        tick = run && ((cnt_q & mask) == mask);
    end

    // Free-running counter, parked at zero while stopped
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end
endmodule

// ===== rtl/acc_pin_ctl.sv
// One shared pin: analog selection overrides digital direction, pull and function
`timescale 1ns/1ns
module acc_pin_ctl (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Software pin settings
    input  wire logic analogSel,
    input  wire logic portDirOut,
    input  wire logic portPullUp,
    input  wire logic altFuncEn,
    // Pad controls
    output logic      padOutEn_q,
    output logic      padPullEn_q,
    output logic      padDigitalEn_q,
    output logic      padAltEn_q
);
    // Registered pad controls with the analog override
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            padOutEn_q     <= 1'b0;
            padPullEn_q    <= 1'b0;
            padDigitalEn_q <= 1'b1;
            padAltEn_q     <= 1'b0;
        end else begin
            padOutEn_q     <= portDirOut && !analogSel;
            padPullEn_q    <= portPullUp && !analogSel;
            padDigitalEn_q <= !analogSel;
            padAltEn_q     <= altFuncEn && !analogSel;
        end
    end
endmodule

// ===== rtl/acc_conv_ctrl.sv
// Converter control: register slave, input routing, start, sequencing, result
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
module acc_conv_ctrl #(
    parameter int NUM_PINS = 8,
    parameter int RES_W    = 12
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    // Avalon-MM slave
    input  wire logic [4:0]          avsAddress,
    input  wire logic                avsRead,
    input  wire logic                avsWrite,
    input  wire logic [31:0]         avsWritedata,
    input  wire logic [3:0]          avsByteenable,
    output logic [31:0]              avsReaddata,
    output logic                     avsWaitrequest,
    // Port settings from the digital I/O block
    input  wire logic [NUM_PINS-1:0] portDirOut,
    input  wire logic [NUM_PINS-1:0] portPullUp,
    input  wire logic [NUM_PINS-1:0] altFuncEn,
    // Pad controls
    output logic [NUM_PINS-1:0]      padOutEn,
    output logic [NUM_PINS-1:0]      padPullEn,
    output logic [NUM_PINS-1:0]      padDigitalEn,
    output logic [NUM_PINS-1:0]      padAltEn,
    // Analog front end controls
    output logic [NUM_PINS-1:0]      externalChannelConnect,
    output logic                     bandgapConnect,
    output logic                     groundConnect,
    output logic [1:0]               referenceSelect,
    output logic                     converterPowerOn,
    output logic                     samplingActive,
    output logic                     convertingActive,
    // Converter result from the analog core
    input  wire logic [RES_W-1:0]    converterData,
    // Interrupt request
    output logic                     conversionIrq
);
    // Register state
    logic [7:0]         ctrl0_q;
    logic [7:0]         ctrl1_q;
    logic [7:0]         pinSel_q;
    logic [RES_W-1:0]   result_q;
    logic               irqFlag_q;
    logic               irqEnable_q;
    logic               waitreq_q;
    logic [31:0]        rdata_q;
    logic               busy_q;
    logic               startPend_q;
    logic               done_q;
    acc_pkg::acc_seq_t  seq_q;
    logic [3:0]         cycCnt_q;

    // Decoded fields
    logic               accept;
    logic               wrEn;
    logic               startBit;
    logic               powerEn;
    logic               alignRight;
    logic [3:0]         chanSel;
    logic [2:0]         srcSel;
    logic [2:0]         divSel;
    logic               convTick;
    logic               startReq;
    logic               lastTick;
    logic [7:0]         resHi;
    logic [7:0]         resLo;
    logic [7:0]         ctrl0Read;

    assign startBit   = ctrl0_q[acc_pkg::CTRL0_START];
    assign powerEn    = ctrl0_q[acc_pkg::CTRL0_EN];
    assign alignRight = ctrl0_q[acc_pkg::CTRL0_ALIGN];
    assign chanSel    = ctrl0_q[acc_pkg::CTRL0_CHAN +: 4];
    assign srcSel     = ctrl1_q[acc_pkg::CTRL1_SRC +: 3];
    assign divSel     = ctrl1_q[acc_pkg::CTRL1_DIV +: 3];

    // Bus handshake: one wait cycle, then the access completes
    assign accept = (avsRead || avsWrite) && waitreq_q;
    assign wrEn   = avsWrite && !waitreq_q && avsByteenable[0];

    // Start request: start bit written low while it stood high
    assign startReq = wrEn && (avsAddress == acc_pkg::OFF_CTRL0) && startBit
                      && !avsWritedata[acc_pkg::CTRL0_START] && powerEn;

    // Result byte formatting
    always_comb begin
        if (alignRight) begin
            resHi = {4'h0, result_q[11:8]};
            resLo = result_q[7:0];
        end else begin
            resHi = result_q[11:4];
            resLo = {result_q[3:0], 4'h0};
        end
        ctrl0Read = ctrl0_q;
        ctrl0Read[acc_pkg::CTRL0_BUSY] = busy_q;
    end

    // Waitrequest generator
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            waitreq_q <= 1'b1;
        end else begin
            waitreq_q <= !accept;
        end
    end

    // Read data captured in the wait cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else if (accept && avsRead) begin
            unique case (avsAddress)
                acc_pkg::OFF_CTRL0:  rdata_q <= {24'h00_0000, ctrl0Read};
                acc_pkg::OFF_CTRL1:  rdata_q <= {24'h00_0000, ctrl1_q};
                acc_pkg::OFF_RES_HI: rdata_q <= {24'h00_0000, resHi};
                acc_pkg::OFF_RES_LO: rdata_q <= {24'h00_0000, resLo};
                acc_pkg::OFF_PINSEL: rdata_q <= {24'h00_0000, pinSel_q};
                acc_pkg::OFF_IRQ:    rdata_q <= {30'h0000_0000, irqEnable_q, irqFlag_q};
                default:             rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Control zero: busy bit is read only and not stored here
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl0_q <= acc_pkg::CTRL0_RESET;
        end else if (wrEn && avsAddress == acc_pkg::OFF_CTRL0) begin
            ctrl0_q <= avsWritedata[7:0] & 8'hbf;
        end
    end

    // Control one and pin selection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl1_q  <= acc_pkg::CTRL1_RESET;
            pinSel_q <= acc_pkg::PINSEL_RESET;
        end else if (wrEn) begin
            if (avsAddress == acc_pkg::OFF_CTRL1) begin
                ctrl1_q <= avsWritedata[7:0];
            end
            if (avsAddress == acc_pkg::OFF_PINSEL) begin
                pinSel_q <= avsWritedata[7:0];
            end
        end
    end

    // Interrupt flag: completion sets, write one clears, set wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqFlag_q   <= 1'b0;
            irqEnable_q <= 1'b0;
        end else begin
            if (wrEn && avsAddress == acc_pkg::OFF_IRQ) begin
                irqEnable_q <= avsWritedata[acc_pkg::IRQ_ENABLE];
            end
            if (done_q) begin
                irqFlag_q <= 1'b1;
            end else if (wrEn && avsAddress == acc_pkg::OFF_IRQ && avsWritedata[acc_pkg::IRQ_FLAG]) begin
                irqFlag_q <= 1'b0;
            end
        end
    end

    // Conversion clock divider
    acc_clk_div #(
        .DIV_W (3)
    ) u_clk_div (
        .clk    (clk),
        .rstn   (rstn),
        .run    (powerEn),
        .divSel (divSel),
        .tick   (convTick)
    );

    assign lastTick = convTick && (cycCnt_q == 4'h1);

    // Sequencer: wait tick, sample four ticks, convert twelve ticks
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seq_q    <= acc_pkg::SEQ_IDLE;
            cycCnt_q <= 4'h0;
        end else if (!powerEn || (startBit && !startReq)) begin
            seq_q    <= acc_pkg::SEQ_IDLE;
            cycCnt_q <= 4'h0;
        end else begin
            unique case (seq_q)
                acc_pkg::SEQ_IDLE: begin
                    if (startReq) begin
                        seq_q <= acc_pkg::SEQ_ARMED;
                    end
                end
                acc_pkg::SEQ_ARMED: begin
                    if (convTick) begin
                        seq_q    <= acc_pkg::SEQ_SAMPLE;
                        cycCnt_q <= acc_pkg::SAMPLE_CYCLES;
                    end
                end
                acc_pkg::SEQ_SAMPLE: begin
                    if (lastTick) begin
                        seq_q    <= acc_pkg::SEQ_CONVERT;
                        cycCnt_q <= acc_pkg::CONVERT_CYCLES;
                    end else if (convTick) begin
                        cycCnt_q <= cycCnt_q - 4'h1;
                    end
                end
                acc_pkg::SEQ_CONVERT: begin
                    if (lastTick) begin
                        seq_q    <= acc_pkg::SEQ_IDLE;
                        cycCnt_q <= 4'h0;
                    end else if (convTick) begin
                        cycCnt_q <= cycCnt_q - 4'h1;
                    end
                end
            endcase
        end
    end

    // Busy flag, completion pulse and result capture
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            result_q <= acc_pkg::RESULT_RESET;
        end else begin
            done_q <= 1'b0;
            if (startReq) begin
                busy_q <= 1'b1;
            end else if (!powerEn || startBit) begin
                busy_q <= 1'b0;
            end else if (seq_q == acc_pkg::SEQ_CONVERT && lastTick) begin
                busy_q   <= 1'b0;
                done_q   <= 1'b1;
                result_q <= converterData;
            end
        end
    end

    // Analog input routing
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            externalChannelConnect <= '0;
            bandgapConnect         <= 1'b0;
            groundConnect          <= 1'b0;
        end else begin
            externalChannelConnect <= '0;
            bandgapConnect         <= (srcSel == acc_pkg::SRC_BANDGAP);
            groundConnect          <= (srcSel >= acc_pkg::SRC_GND_LO)
                                      && (srcSel <= acc_pkg::SRC_GND_HI);
            if ((srcSel == acc_pkg::SRC_EXT0 || srcSel > acc_pkg::SRC_GND_HI) && !chanSel[3]) begin
                externalChannelConnect[chanSel[2:0]] <= 1'b1;
            end
        end
    end

    // Front end status and interrupt output
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            referenceSelect  <= 2'h0;
            converterPowerOn <= 1'b0;
            samplingActive   <= 1'b0;
            convertingActive <= 1'b0;
            conversionIrq    <= 1'b0;
        end else begin
            referenceSelect  <= ctrl1_q[acc_pkg::CTRL1_REF +: 2];
            converterPowerOn <= powerEn;
            samplingActive   <= (seq_q == acc_pkg::SEQ_SAMPLE);
            convertingActive <= (seq_q == acc_pkg::SEQ_CONVERT);
            conversionIrq    <= irqFlag_q && irqEnable_q;
        end
    end

    assign avsWaitrequest = waitreq_q;
    assign avsReaddata    = rdata_q;

    // One override cell per shared pin
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        acc_pin_ctl u_pin (
            .clk            (clk),
            .rstn           (rstn),
            .analogSel      (pinSel_q[p]),
            .portDirOut     (portDirOut[p]),
            .portPullUp     (portPullUp[p]),
            .altFuncEn      (altFuncEn[p]),
            .padOutEn_q     (padOutEn[p]),
            .padPullEn_q    (padPullEn[p]),
            .padDigitalEn_q (padDigitalEn[p]),
            .padAltEn_q     (padAltEn[p])
        );
    end
endmodule

// ===== bench/acc_conv_props.sv
// Port checker for the conversion control block
`timescale 1ns/1ns
module acc_conv_props #(
    parameter int NUM_PINS = 8,
    parameter int RES_W    = 12
) (
    // Clock, reset and bus handshake
    input wire logic                clk,
    input wire logic                rstn,
    input wire logic                avsRead,
    input wire logic                avsWrite,
    input wire logic                avsWaitrequest,
    // Digital pin settings and pad controls
    input wire logic [NUM_PINS-1:0] portDirOut,
    input wire logic [NUM_PINS-1:0] portPullUp,
    input wire logic [NUM_PINS-1:0] altFuncEn,
    input wire logic [NUM_PINS-1:0] padOutEn,
    input wire logic [NUM_PINS-1:0] padPullEn,
    input wire logic [NUM_PINS-1:0] padDigitalEn,
    input wire logic [NUM_PINS-1:0] padAltEn,
    // Analog front end
    input wire logic [NUM_PINS-1:0] externalChannelConnect,
    input wire logic                bandgapConnect,
    input wire logic                groundConnect,
    input wire logic                converterPowerOn,
    input wire logic                samplingActive,
    input wire logic                convertingActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Bus answers one cycle after a request, low for one cycle only
    property p_bus_ans; (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest; endproperty
    a_bus_ans: assert property (p_bus_ans) else $error("request not answered");
    property p_bus_one; !avsWaitrequest |=> avsWaitrequest; endproperty
    a_bus_one: assert property (p_bus_one) else $error("waitrequest low too long");
    // Analog pins lose pull-up, alternate function and drive
    property p_pull; (padPullEn & ~($past(portPullUp) & padDigitalEn)) == '0; endproperty
    a_pull: assert property (p_pull) else $error("pull-up without request");
    property p_alt; (padAltEn & ~($past(altFuncEn) & padDigitalEn)) == '0; endproperty
    a_alt: assert property (p_alt) else $error("alternate function without request");
    property p_dir; (padOutEn & ~($past(portDirOut) & padDigitalEn)) == '0; endproperty
    a_dir: assert property (p_dir) else $error("output drive without request");
    // Input routing exclusive
    property p_onehot; $onehot0(externalChannelConnect); endproperty
    a_onehot: assert property (p_onehot) else $error("several channels connected");
    property p_src; bandgapConnect |-> !groundConnect && externalChannelConnect == '0; endproperty
    a_src: assert property (p_src) else $error("bandgap shares the input");
    // Powered down means no sequencing
    property p_pwr; !converterPowerOn && !$past(converterPowerOn) |-> !samplingActive && !convertingActive; endproperty
    a_pwr: assert property (p_pwr) else $error("sequencing while unpowered");
    // Conversion follows sampling directly
    property p_seq; $rose(convertingActive) |-> $past(samplingActive) && !samplingActive; endproperty
    a_seq: assert property (p_seq) else $error("converting without sampling");

    // Main scenarios reached
    c_conv: cover property ($fell(convertingActive));
    c_bg: cover property (bandgapConnect);
    c_pin: cover property (padPullEn != portPullUp);
endmodule

// ===== bench/acc_analog_src.sv
// Analog sources behind the converter input: pins, bandgap, ground
`timescale 1ns/1ns
module acc_analog_src #(
    parameter logic [11:0] BANDGAP_CODE = 12'h5a3
) (
    // Clock
    input  wire logic        clk,
    // Input switches
    input  wire logic [7:0]  externalChannelConnect,
    input  wire logic        bandgapConnect,
    input  wire logic        groundConnect,
    // Code seen by the converter
    output logic      [11:0] converterData
);
    logic [11:0] floatQ = 12'h000;
    // Floating input wanders every cycle
    always @(posedge clk) floatQ <= floatQ + 12'h3a7;
    // Selected source drives the converter
    always_comb begin
        converterData = floatQ;
        for (int i = 0; i < 8; i++) if (externalChannelConnect[i]) converterData = 12'(i) * 12'h111 ^ 12'ha5c;
        if (bandgapConnect) converterData = BANDGAP_CODE;
        if (groundConnect) converterData = 12'h000;
    end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the conversion control block
`timescale 1ns/1ns
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin failCount++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    // Design inputs
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [4:0]  avsAddress = 5'h00;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [3:0]  avsByteenable = 4'hf;
    logic [7:0]  portDirOut = 8'h00, portPullUp = 8'h00, altFuncEn = 8'h00;
    // Design outputs
    logic [31:0] avsReaddata;
    logic        avsWaitrequest, bgConn, gndConn, pwrOn, sampAct, convAct, irq;
    logic [7:0]  padOutEn, padPullEn, padDigitalEn, padAltEn, extConn;
    logic [1:0]  refSel;
    logic [11:0] convData;
    // Bench state
    int          failCount = 0, numChecks = 0, cycles = 0, sampCnt = 0, convCnt = 0;
    logic        al, ie, ext;
    logic [1:0]  r;
    logic [2:0]  src;
    logic [3:0]  chan;
    logic [7:0]  rd, v, hiE, loE;
    logic [11:0] expD;
    localparam int SETTLE_CYCLES = 8; // Settling wait after power-up, chosen length

    acc_conv_ctrl i_dut (.clk(clk), .rstn(rstn), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .portDirOut(portDirOut), .portPullUp(portPullUp), .altFuncEn(altFuncEn),
        .padOutEn(padOutEn), .padPullEn(padPullEn), .padDigitalEn(padDigitalEn), .padAltEn(padAltEn),
        .externalChannelConnect(extConn), .bandgapConnect(bgConn), .groundConnect(gndConn),
        .referenceSelect(refSel), .converterPowerOn(pwrOn), .samplingActive(sampAct),
        .convertingActive(convAct), .converterData(convData), .conversionIrq(irq));
    acc_analog_src i_src (.clk(clk), .externalChannelConnect(extConn), .bandgapConnect(bgConn),
        .groundConnect(gndConn), .converterData(convData));

    // System clock
    always #5 clk = ~clk;

    // Cycle count, phase lengths and timeout
    always @(posedge clk) begin
        cycles++;
        if (sampAct === 1'b1) sampCnt++;
        if (convAct === 1'b1) convCnt++;
        if (cycles == 40000) begin
            failCount++;
            endSim();
        end
    end

    // Verdict and end of run
    task automatic endSim();
        if (failCount == 0 && numChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One bus access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk);
        avsAddress <= a;
        avsWrite <= w;
        avsRead <= !w;
        avsWritedata <= {24'h0, d};
        avsByteenable <= be;
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        rd = avsReaddata[7:0];
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'hf);
        `CHK(rd, e)
    endtask

    // Main sequence
    initial begin
        void'($urandom(32'ha4ed3b6a));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        // Reset values, unmapped, masked and read-only accesses
        for (int a = 0; a < 8; a++) rdc(5'(a * 4), 8'h00);
        wr(5'h18, 8'hff);
        rdc(5'h18, 8'h00);
        bus(1'b1, 5'h04, 8'h5b, 4'he);
        rdc(5'h04, 8'h00);
        wr(5'h00, 8'h40);
        rdc(5'h00, 8'h00);
        // Analog pin selection overrides digital settings
        repeat (4) begin
            v = 8'($urandom);
            portDirOut <= 8'($urandom);
            portPullUp <= 8'($urandom);
            altFuncEn <= 8'($urandom);
            wr(5'h10, v);
            repeat (2) @(posedge clk);
            `CHK(padOutEn, portDirOut & ~v)
            `CHK(padPullEn, portPullUp & ~v)
            `CHK(padAltEn, altFuncEn & ~v)
            `CHK(padDigitalEn, ~v)
        end
        // Input routing over every source code and channel, except channels 0 to 7 with source codes 1 to 4
        for (int s = 0; s < 8; s++) begin
            for (int c = 0; c < 16; c++) begin
                ext = (s == 0 || s > 4);
                if (!ext && c < 8) continue;
                r = 2'($urandom);
                wr(5'h04, {3'(s), r, 3'h0});
                wr(5'h00, 8'(c));
                repeat (2) @(posedge clk);
                `CHK(extConn, (ext && c < 8) ? 8'h01 << c : 8'h00)
                `CHK(bgConn, s == 1)
                `CHK(gndConn, s > 1 && s < 5)
                `CHK(refSel, r)
            end
        end
        // Conversions at every divider, both alignments, interrupt on and off; the last divider converts the bandgap
        for (int d = 0; d < 8; d++) begin
            al = d[0];
            ie = d[1];
            src = (d == 7) ? 3'h1 : 3'h0;
            chan = (d == 7) ? 4'h8 : 4'(d);
            expD = (d == 7) ? 12'h5a3 : 12'(d) * 12'h111 ^ 12'ha5c;
            hiE = al ? {4'h0, expD[11:8]} : expD[11:4];
            loE = al ? expD[7:0] : {expD[3:0], 4'h0};
            wr(5'h10, 8'h01 << d);
            wr(5'h14, {6'h0, ie, 1'b1});
            rdc(5'h14, {6'h0, ie, 1'b0});
            `CHK(irq, 1'b0)
            wr(5'h04, {src, 2'b00, 3'(d)});
            wr(5'h00, {3'b001, al, chan});
            repeat (SETTLE_CYCLES) @(posedge clk);
            wr(5'h00, {3'b101, al, chan});
            sampCnt = 0;
            convCnt = 0;
            wr(5'h00, {3'b001, al, chan});
            rdc(5'h00, {3'b011, al, chan});
            `CHK(pwrOn, 1'b1)
            for (int k = 0; k < 1000 && rd[6] !== 1'b0; k++) bus(1'b0, 5'h00, 8'h00, 4'hf);
            `CHK(rd[6], 1'b0)
            `CHK(sampCnt, 4 << d)
            `CHK(convCnt, 12 << d)
            rdc(5'h14, {6'h0, ie, 1'b1});
            `CHK(irq, ie)
            rdc(5'h08, hiE);
            rdc(5'h0c, loE);
            wr(5'h00, {3'b000, al, chan});
            rdc(5'h08, hiE);
            rdc(5'h0c, loE);
            `CHK(pwrOn, 1'b0)
        end
        // Start refused while unpowered
        wr(5'h00, 8'h80);
        wr(5'h00, 8'h00);
        rdc(5'h00, 8'h00);
        `CHK(sampAct, 1'b0)
        endSim();
    end
endmodule

bind acc_conv_ctrl acc_conv_props #(.NUM_PINS(NUM_PINS), .RES_W(RES_W)) i_props (.clk(clk), .rstn(rstn),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWaitrequest(avsWaitrequest), .portDirOut(portDirOut),
    .portPullUp(portPullUp), .altFuncEn(altFuncEn), .padOutEn(padOutEn), .padPullEn(padPullEn),
    .padDigitalEn(padDigitalEn),
    .padAltEn(padAltEn), .externalChannelConnect(externalChannelConnect), .bandgapConnect(bandgapConnect),
    .groundConnect(groundConnect), .converterPowerOn(converterPowerOn), .samplingActive(samplingActive),
    .convertingActive(convertingActive));
